// [core/sms_slave.sv]
// SMBus slave front end: address match, pointer, register write and read.
// Assumes bus pins arrive asynchronously; register file lives outside.
// Behaviour
// - Fixed variant answers only the 7-bit address 0101110.
// - First byte after start is address plus direction bit.
// - Strap high gives 0101110; low selects 0101100 or 0101101 by pin.
// - Straps sampled after reset; address latched at eighth rising edge of match.
// - Each byte is eight bits MSB first then an acknowledge bit.
// - Data changes only with clock low; rising data at clock high is stop.
// - Writes take one or two bytes; reads return one byte.
// - First write byte loads pointer; second writes selected register.
// - Read returns register selected by current pointer.
// - Pointer-only write: address, index, both acknowledged, stop.
// - Register write: address, index, data, each acknowledged, stop.
// - Repeated start begins a new operation without stop.
// - Combined read byte: index write then repeated-start read.
// - No activity for 35 ms releases the bus unless disabled.
// - Receive byte: address with read, one byte, master nack, stop.
`timescale 1ns/100ps
`default_nettype none
module sms_slave
   import sms_pkg::*;
#(
   parameter int TIMEOUT_COUNT = TIMEOUT_CYC
) (
   // Clock and reset
   input  wire  logic       core_clk,
   input  wire  logic       rst,
   // Bus pins
   input  wire  logic       sclIn,
   input  wire  logic       sdaIn,
   output var   logic       sdaOut,
   output var   logic       sdaOe,
   // Straps and configuration
   input  wire  logic       variantSelectable,
   input  wire  logic       addressStrapEnablePin,
   input  wire  logic       addressSelectPin,
   input  wire  logic       busIdleTimeoutDisable,
   // Register file side
   output var   logic [7:0] regPtr,
   output var   logic [7:0] regWrData,
   output var   logic       regWrStrobe,
   output var   logic       regRdStrobe,
   input  wire  logic [7:0] regRdData,
   // Status
   output var   logic [6:0] slaveAddr,
   output var   logic       addrLocked
);

   typedef struct packed {
      logic [1:0]  sclSync;
      logic [1:0]  sdaSync;
      logic        sclPrev;
      logic        sdaPrev;
      logic        strapDone;
      logic [1:0]  strapEnSync;
      logic [1:0]  strapSelSync;
      logic [1:0]  strapWait;
      logic [6:0]  addr;
      logic        locked;
      sms_state_t  state;
      logic [3:0]  bitCnt;
      logic [7:0]  shift;
      logic        rnw;
      logic [1:0]  byteIdx;
      logic        match;
      logic [7:0]  ptr;
      logic [7:0]  wData;
      logic        wStb;
      logic        rStb;
      logic        sdaOe;
      logic [31:0] idleCnt;
   } sms_regs_t;

   sms_regs_t r_q;
   sms_regs_t r_d;

   // Strap decode to a 7-bit address
   function automatic logic [6:0] strapAddr(input logic sel, input logic en, input logic pin);
      logic [6:0] a;
      a = ADDR_FIXED;
      if (sel && !en) begin
         a = pin ? ADDR_SEL_HIGH : ADDR_SEL_LOW;
      end
      return a;
   endfunction : strapAddr

   // Shift one bus bit in at the bottom, MSB first
   function automatic logic [7:0] shiftIn(input logic [7:0] s, input logic b);
      return {s[6:0], b};
   endfunction : shiftIn

   // Bit counter step, wraps from all ones to zero
   function automatic logic [3:0] nextBit(input logic [3:0] c);
      return c + 4'd1;
   endfunction : nextBit

   logic scl;
   logic sda;
   logic sclRise;
   logic sclFall;
   logic startCond;
   logic stopCond;
   logic busActive;
   logic timedOut;
   logic addrHit;

   assign scl       = r_q.sclSync[1];
   assign sda       = r_q.sdaSync[1];
   assign sclRise   = scl && !r_q.sclPrev;
   assign sclFall   = !scl && r_q.sclPrev;
   assign startCond = scl && r_q.sclPrev && r_q.sdaPrev && !sda;
   assign stopCond  = scl && r_q.sclPrev && !r_q.sdaPrev && sda;

   assign busActive = sclRise || sclFall || startCond || stopCond;
   assign timedOut  = !busIdleTimeoutDisable && (r_q.idleCnt >= 32'(TIMEOUT_COUNT));

   assign addrHit   = (r_q.shift[6:0] == r_q.addr);

   always_comb begin
      r_d         = r_q;
      r_d.sclSync = {r_q.sclSync[0], sclIn};
      r_d.sdaSync = {r_q.sdaSync[0], sdaIn};
      r_d.sclPrev = scl;
      r_d.sdaPrev = sda;
      r_d.wStb    = 1'b0;
      r_d.rStb    = 1'b0;

      // Strap pins through two flip-flops
      r_d.strapEnSync  = {r_q.strapEnSync[0], addressStrapEnablePin};
      r_d.strapSelSync = {r_q.strapSelSync[0], addressSelectPin};

      if (!r_q.strapDone) begin
         if (r_q.strapWait[1]) begin
            r_d.strapDone = 1'b1;
            r_d.addr      = strapAddr(variantSelectable,
                                      r_q.strapEnSync[1],
                                      r_q.strapSelSync[1]);
         end else begin
            r_d.strapWait = r_q.strapWait + 2'd1;
         end
      end

      if (busActive || r_q.state == ST_IDLE) begin
         r_d.idleCnt = '0;
      end else if (r_q.idleCnt < 32'(TIMEOUT_COUNT)) begin
         r_d.idleCnt = r_q.idleCnt + 32'd1;
      end

      if (startCond) begin
         r_d.state  = ST_ADDR;
         // Clock fall after start wraps count to zero
         r_d.bitCnt = '1;
         r_d.sdaOe  = 1'b0;
         r_d.match  = 1'b0;
      end else if (stopCond) begin
         r_d.state = ST_IDLE;
         r_d.sdaOe = 1'b0;
      end else if (timedOut) begin
         r_d.state = ST_IDLE;
         r_d.sdaOe = 1'b0;
      end else begin
         unique case (r_q.state)
            ST_IDLE, ST_IGN: begin
               r_d.sdaOe = 1'b0;
            end
            ST_ADDR: begin
               if (sclRise && r_q.bitCnt < BIT_ACK) begin
                  r_d.shift = shiftIn(r_q.shift, sda);
                  if (r_q.bitCnt == BIT_LATCH) begin
                     r_d.match = addrHit;
                     if (addrHit) begin
                        r_d.locked = 1'b1;
                     end
                     r_d.rnw = sda;
                  end
               end
               if (sclFall) begin
                  if (r_q.bitCnt == BIT_ACK) begin
                     r_d.sdaOe  = 1'b0;
                     r_d.bitCnt = '0;
                     r_d.byteIdx = DATA_IDX_PTR;
                     if (!r_q.match) begin
                        r_d.state = ST_IGN;
                     end else if (r_q.rnw) begin
                        r_d.state = ST_READ;
                        r_d.shift = regRdData;
                        r_d.rStb  = 1'b1;
                        r_d.sdaOe = !regRdData[7];
                     end else begin
                        r_d.state = ST_WRITE;
                     end
                  end else begin
                     r_d.bitCnt = nextBit(r_q.bitCnt);
                     if (r_q.bitCnt == BIT_LATCH) begin
                        r_d.sdaOe = r_q.match;
                     end
                  end
               end
            end
            ST_WRITE: begin
               if (sclRise && r_q.bitCnt < BIT_ACK) begin
                  r_d.shift = shiftIn(r_q.shift, sda);
               end
               if (sclFall) begin
                  if (r_q.bitCnt == BIT_ACK) begin
                     r_d.sdaOe  = 1'b0;
                     r_d.bitCnt = '0;
                  end else begin
                     r_d.bitCnt = nextBit(r_q.bitCnt);
                     if (r_q.bitCnt == BIT_LATCH) begin
                        r_d.sdaOe = (r_q.byteIdx != DATA_IDX_EXTRA);
                        if (r_q.byteIdx == DATA_IDX_PTR) begin
                           r_d.ptr = r_q.shift;
                        end else if (r_q.byteIdx == DATA_IDX_WDATA) begin
                           r_d.wData = r_q.shift;
                           r_d.wStb  = 1'b1;
                        end
                        if (r_q.byteIdx != DATA_IDX_EXTRA) begin
                           r_d.byteIdx = r_q.byteIdx + 2'd1;
                        end
                     end
                  end
               end
            end
            ST_READ: begin
               if (sclFall) begin
                  if (r_q.bitCnt == BIT_LATCH) begin
                     // one byte only, release for master nack
                     r_d.sdaOe  = 1'b0;
                     r_d.bitCnt = BIT_ACK;
                  end else if (r_q.bitCnt == BIT_ACK) begin
                     r_d.state = ST_IGN;
                  end else begin
                     r_d.bitCnt = nextBit(r_q.bitCnt);
                     r_d.shift  = shiftIn(r_q.shift, 1'b0);
                     r_d.sdaOe  = !r_q.shift[6];
                  end
               end
            end
            default: begin
               r_d.state = ST_IDLE;
               r_d.sdaOe = 1'b0;
            end
         endcase
      end

      if (r_q.locked) begin
         r_d.addr = r_q.addr;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         r_q         <= '0;
         r_q.sclSync <= 2'h3;
         r_q.sdaSync <= 2'h3;
         r_q.sclPrev <= 1'b1;
         r_q.sdaPrev <= 1'b1;
         r_q.addr    <= ADDR_FIXED;
         r_q.state   <= ST_IDLE;
         r_q.ptr     <= PTR_RESET;
      end else begin
         r_q <= r_d;
      end
   end

   assign sdaOut      = 1'b0;
   assign sdaOe       = r_q.sdaOe;
   assign regPtr      = r_q.ptr;
   assign regWrData   = r_q.wData;
   assign regWrStrobe = r_q.wStb;
   assign regRdStrobe = r_q.rStb;
   assign slaveAddr   = r_q.addr;
   assign addrLocked  = r_q.locked;

endmodule : sms_slave
`default_nettype wire

// [core/sms_pkg.sv]
// Constants for the SMBus slave register access block.
// Assumes one 40 MHz core clock and a synchronous active-high reset.
package sms_pkg;
   localparam int          CLK_HZ          = 40_000_000;
   localparam int          TIMEOUT_MS      = 35;
   localparam int          TIMEOUT_CYC     = CLK_HZ / 1000 * TIMEOUT_MS;
   localparam logic [6:0]  ADDR_FIXED      = 7'h2e;
   localparam logic [6:0]  ADDR_SEL_LOW    = 7'h2c;
   localparam logic [6:0]  ADDR_SEL_HIGH   = 7'h2d;
   localparam logic [3:0]  BIT_ACK         = 4'h8;
   localparam logic [3:0]  BIT_LATCH       = 4'h7;
   localparam logic [7:0]  PTR_RESET       = 8'h00;
   localparam logic [1:0]  DATA_IDX_PTR    = 2'h0;
   localparam logic [1:0]  DATA_IDX_WDATA  = 2'h1;
   localparam logic [1:0]  DATA_IDX_EXTRA  = 2'h2;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_ADDR  = 5'b00010,
      ST_WRITE = 5'b00100,
      ST_READ  = 5'b01000,
      ST_IGN   = 5'b10000
   } sms_state_t;
endpackage : sms_pkg

// [testbench/sms_slave_props.sv]
// Checker for the SMBus slave ports.
// Assumes one core clock domain with synchronous rst.
`timescale 1ns/100ps
`default_nettype none
module sms_slave_props #(parameter int TIMEOUT_COUNT = 2000) (
   input wire logic       core_clk, rst, sclIn, sdaIn, sdaOut, sdaOe,
   input wire logic       busIdleTimeoutDisable, regWrStrobe, regRdStrobe, addrLocked,
   input wire logic [6:0] slaveAddr
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   int stallCnt_q;
   always_ff @(posedge core_clk)
      stallCnt_q <= (rst || !sdaOe || $changed(sclIn)) ? 0 : stallCnt_q + 1;
   a_wr_strobe_pulse: assert property (regWrStrobe |=> !regWrStrobe) else $error("write strobe long");
   a_wr_needs_lock: assert property (regWrStrobe |-> addrLocked) else $error("write unaddressed");
   a_rd_needs_lock: assert property (regRdStrobe |-> addrLocked && !$past(regRdStrobe)) else $error("read strobe bad");
   a_lock_freezes_addr: assert property (addrLocked |=> addrLocked && $stable(slaveAddr)) else $error("address moved");
   a_locked_addr_legal: assert property (addrLocked |-> slaveAddr inside {7'h2c, 7'h2d, 7'h2e}) else $error("bad address");
   a_sda_moves_low: assert property ($changed(sdaOe) |-> !sclIn) else $error("data moved at clock high");
   a_ack_held: assert property ($rose(sdaOe) |=> sdaOe [*4]) else $error("drive too short");
   a_bus_released: assert property (!busIdleTimeoutDisable |-> stallCnt_q <= TIMEOUT_COUNT + 8) else $error("bus not released");
   a_drive_low_only: assert property (!sdaOut) else $error("data driven high");
endmodule : sms_slave_props
bind sms_slave sms_slave_props #(.TIMEOUT_COUNT(TIMEOUT_COUNT)) u_sms_slave_props (.*);
`default_nettype wire

// [testbench/sms_host_model.sv]
// SMBus host master model; bus clock period 8 core cycles.
// Assumes a pulled-up data wire resolved by the bench.
`timescale 1ns/100ps
`default_nettype none
module sms_host_model (
   input wire logic core_clk, sda,
   output var logic scl, sdaLow
);
   initial begin scl = 1; sdaLow = 0; end
   task automatic cyc(int n); repeat (n) @(negedge core_clk); endtask : cyc
   task automatic bitx(input logic b, output logic s);
      cyc(2); sdaLow = ~b; cyc(2); scl = 1; cyc(2); s = sda; cyc(2); scl = 0;
   endtask : bitx
   task automatic start;
      if (!scl) begin cyc(2); sdaLow = 0; cyc(2); scl = 1; cyc(2); end
      sdaLow = 1; cyc(4); scl = 0;
   endtask : start
   task automatic stop;
      cyc(2); sdaLow = 1; cyc(2); scl = 1; cyc(2); sdaLow = 0; cyc(4);
   endtask : stop
   task automatic wr(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bitx(b[i], s);
      bitx(1'b1, s); ack = ~s;
   endtask : wr
   task automatic rd(output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
      bitx(1'b1, s);
   endtask : rd
endmodule : sms_host_model
`default_nettype wire

// [testbench/sms_slave_tb_top.sv]
// Bench for the SMBus slave with a host model and a register file model.
// Assumes read data is the pointer xor 0xa5.
`timescale 1ns/100ps
`default_nettype none
module sms_slave_tb_top;
   import sms_pkg::*;
   logic core_clk = 0, rst = 1, strapEn = 0, selPin = 1, bus_idle_timeout_disable = 0;
   logic scl, sdaLow, sdaOut, sdaOe, wrS, rdS, locked, ack;
   logic [7:0] ptr, wrD, d, wrPtr = 0, wrDat = 0;
   logic [6:0] sAddr;
   int n_errors = 0, checks = 0, wrCnt = 0, cycles = 0, rdCnt = 0;
   wire sda = !((sdaOe && !sdaOut) || sdaLow);
   always #12.5 core_clk = ~core_clk;
   sms_host_model u_sms_host_model (.core_clk(core_clk), .sda(sda), .scl(scl), .sdaLow(sdaLow));
   sms_slave #(.TIMEOUT_COUNT(2000)) u_sms_slave (.core_clk(core_clk), .rst(rst), .sclIn(scl),
      .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .variantSelectable(1'b1),
      .addressStrapEnablePin(strapEn), .addressSelectPin(selPin), .busIdleTimeoutDisable(bus_idle_timeout_disable),
      .regPtr(ptr), .regWrData(wrD), .regWrStrobe(wrS), .regRdStrobe(rdS),
      .regRdData(ptr ^ 8'ha5), .slaveAddr(sAddr), .addrLocked(locked));
   always @(posedge core_clk) begin
      if (wrS === 1'b1) begin wrPtr <= ptr; wrDat <= wrD; wrCnt <= wrCnt + 1; end
      if (rdS === 1'b1) rdCnt <= rdCnt + 1;
      cycles <= cycles + 1;
      if (cycles == 20000) begin n_errors++; end_of_test; end
   end
   task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++; $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic end_of_test;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_of_test
   task automatic reset_dut;
      rst = 1; repeat (3) @(negedge core_clk); rst = 0; repeat (6) @(negedge core_clk);
   endtask : reset_dut
   task automatic t_write;
      u_sms_host_model.start; u_sms_host_model.wr(8'h5a, ack);
      chk("addr ack", 1, ack);
      selPin = 0;
      u_sms_host_model.wr(8'h3a, ack); chk("index ack", 1, ack);
      u_sms_host_model.wr(8'h96, ack); chk("data ack", 1, ack);
      u_sms_host_model.stop;
      chk("write ptr", 8'h3a, wrPtr);
      chk("write data", 8'h96, wrDat);
      chk("addr frozen", 8'h2d, {1'b0, sAddr});
      chk("addr locked", 8'h01, {7'h00, locked});
   endtask : t_write
   task automatic t_combined;
      u_sms_host_model.start; u_sms_host_model.wr(8'h5a, ack); u_sms_host_model.wr(8'h41, ack);
      u_sms_host_model.start; u_sms_host_model.wr(8'h5b, ack);
      chk("read ack", 1, ack);
      u_sms_host_model.rd(d); u_sms_host_model.stop;
      chk("read byte", 8'h41 ^ 8'ha5, d);
   endtask : t_combined
   task automatic t_receive;
      int n;
      n = rdCnt;
      u_sms_host_model.start; u_sms_host_model.wr(8'h5b, ack); u_sms_host_model.rd(d);
      u_sms_host_model.stop;
      chk("receive byte", 8'h41 ^ 8'ha5, d);
      chk("read strobes", 8'(n + 1), 8'(rdCnt));
   endtask : t_receive
   task automatic t_extra;
      int n;
      n = wrCnt;
      u_sms_host_model.start; u_sms_host_model.wr(8'h5a, ack); u_sms_host_model.wr(8'h07, ack);
      u_sms_host_model.wr(8'h11, ack); u_sms_host_model.wr(8'h22, ack);
      chk("third byte ack", 0, ack);
      u_sms_host_model.stop;
      chk("write count", 8'(n + 1), 8'(wrCnt));
   endtask : t_extra
   task automatic t_nomatch;
      u_sms_host_model.start; u_sms_host_model.wr(8'h5c, ack);
      chk("foreign ack", 0, ack);
      u_sms_host_model.wr(8'h3a, ack); chk("ignored ack", 0, ack);
      u_sms_host_model.stop; chk("ptr kept", 8'h07, ptr);
   endtask : t_nomatch
   task automatic t_fixed;
      strapEn = 1; reset_dut;
      chk("unlocked", 8'h00, {7'h00, locked});
      u_sms_host_model.start; u_sms_host_model.wr(8'h5c, ack);
      chk("fixed ack", 1, ack);
      u_sms_host_model.wr(8'h12, ack); u_sms_host_model.stop;
      chk("pointer only", 8'h12, ptr);
   endtask : t_fixed
   initial begin
      reset_dut;
      t_write; t_combined; t_receive; t_extra; t_nomatch; t_fixed;
      end_of_test;
   end
endmodule : sms_slave_tb_top
`default_nettype wire
